// >>> muldiv_pkg.sv
`default_nettype none

package muldiv_pkg;

  localparam int unsigned WORD_WIDTH    = 16;
  localparam int unsigned FRAC_WIDTH    = 15;
  localparam int unsigned CLK_PERIOD_NS = 25;

  // Longest allowed execution times, rounded down to whole clock cycles
  localparam int unsigned MUL_TIME_NS   = 10000;
  localparam int unsigned DIV_TIME_NS   = 13000;
  localparam int unsigned MUL_CYCLES    = MUL_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned DIV_CYCLES    = DIV_TIME_NS / CLK_PERIOD_NS;

  localparam logic [4:0]  MUL_LAST_STEP = 5'h0f;
  localparam logic [4:0]  DIV_LAST_STEP = 5'h0e;
  localparam logic [15:0] MINUS_ONE     = 16'h8000;

  typedef enum logic [3:0] {
    S_IDLE     = 4'b0000,
    S_WAIT_END = 4'b0001,
    S_FETCH1   = 4'b0010,
    S_FETCH2   = 4'b0011,
    S_SETUP    = 4'b0100,
    S_CALC     = 4'b0101,
    S_WRITE    = 4'b0110,
    S_FINISH   = 4'b0111,
    S_OVERFLOW = 4'b1000
  } state_type;

endpackage

`default_nettype wire

// >>> hw_multiply_divide_unit.sv
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// [RULE_01] A multiply takes the multiplicand from the accumulator and the multiplier from the word at the first pointer.
// [RULE_02] A finished multiply loads the high product half into the accumulator and writes the low half to the second pointer's word.
// [RULE_03] A divide takes the high dividend from the accumulator, the low dividend from the first pointer's word and the divisor from the second.
// [RULE_04] A finished divide loads the quotient into the accumulator.
// [RULE_05] A multiply completes within 10 microseconds.
// [RULE_06] A divide completes within 13 microseconds.
// [RULE_07] The unit suspends the processor only after its current instruction ends and holds it while using memory and registers.
// [RULE_08] On multiply or divide overflow no operand changes and the overflow indicator is turned on.
// [RULE_09] The processor is released only after every result word has been written back.
module hw_multiply_divide_unit
  import muldiv_pkg::*;
(
  input  wire logic                         sys_clk,
  input  wire logic                         resetn,
  input  wire logic                         op_start,
  input  wire logic                         op_divide,
  input  wire logic [muldiv_pkg::WORD_WIDTH-1:0] acc_in,
  input  wire logic [muldiv_pkg::WORD_WIDTH-1:0] ptr_a,
  input  wire logic [muldiv_pkg::WORD_WIDTH-1:0] ptr_b,
  input  wire logic                         instr_end,
  output logic                              suspend,
  output logic                              busy,
  output logic                              mem_req,
  output logic                              mem_we,
  output logic [muldiv_pkg::WORD_WIDTH-1:0] mem_addr,
  output logic [muldiv_pkg::WORD_WIDTH-1:0] mem_wdata,
  input  wire logic [muldiv_pkg::WORD_WIDTH-1:0] mem_rdata,
  input  wire logic                         mem_ack,
  output logic                              acc_load,
  output logic [muldiv_pkg::WORD_WIDTH-1:0] acc_out,
  output logic                              overflow_set
);
  import muldiv_pkg::*;

  function automatic logic [15:0] abs16(input logic [15:0] x);
    abs16 = x[15] ? 16'(-x) : x;
  endfunction

  function automatic logic [30:0] abs31(input logic [30:0] x);
    abs31 = x[30] ? 31'(-x) : x;
  endfunction

  function automatic logic [30:0] next_prod_signed(input logic [30:0] p, input logic n);
    next_prod_signed = n ? 31'(-p) : p;
  endfunction

  state_type   state,   next_state;
  logic        op_div,  next_op_div;
  logic [15:0] acc_q,   next_acc_q;
  logic [15:0] pa,      next_pa;
  logic [15:0] pb,      next_pb;
  logic [15:0] opnd1,   next_opnd1;
  logic [15:0] opnd2,   next_opnd2;
  logic [15:0] mag_a,   next_mag_a;
  logic [15:0] mag_b,   next_mag_b;
  logic [30:0] prod,    next_prod;
  logic [15:0] rem,     next_rem;
  logic [14:0] dq,      next_dq;
  logic [4:0]  cnt,     next_cnt;
  logic        neg,     next_neg;
  logic [15:0] next_acc_out;
  logic [15:0] next_mem_wdata;

  logic [30:0] dmag;
  logic [16:0] trial;

  always_comb begin
    dmag  = abs31({acc_q, opnd1[14:0]});
    trial = {rem, dq[14]};
  end

  always_comb begin
    next_state     = state;
    next_op_div    = op_div;
    next_acc_q     = acc_q;
    next_pa        = pa;
    next_pb        = pb;
    next_opnd1     = opnd1;
    next_opnd2     = opnd2;
    next_mag_a     = mag_a;
    next_mag_b     = mag_b;
    next_prod      = prod;
    next_rem       = rem;
    next_dq        = dq;
    next_cnt       = cnt;
    next_neg       = neg;
    next_acc_out   = acc_out;
    next_mem_wdata = mem_wdata;
    case (state)
      S_IDLE: begin
        if (op_start) begin
          next_op_div = op_divide;
          next_pa     = ptr_a;
          next_pb     = ptr_b;
          next_state  = S_WAIT_END;
        end
      end
      // [RULE_07] Suspend at instruction end
      S_WAIT_END: begin
        if (instr_end) begin
          next_acc_q = acc_in;
          next_state = S_FETCH1;
        end
      end
      // [RULE_01] Multiplier or low dividend
      S_FETCH1: begin
        if (mem_ack) begin
          next_opnd1 = mem_rdata;
          next_state = op_div ? S_FETCH2 : S_SETUP;
        end
      end
      // [RULE_03] Divisor fetch
      S_FETCH2: begin
        if (mem_ack) begin
          next_opnd2 = mem_rdata;
          next_state = S_SETUP;
        end
      end
      // [RULE_08] Overflow detection
      S_SETUP: begin
        next_cnt  = 5'h00;
        next_prod = '0;
        if (!op_div) begin
          next_mag_a = abs16(acc_q);
          next_mag_b = abs16(opnd1);
          next_neg   = acc_q[15] ^ opnd1[15];
          next_state = (acc_q == MINUS_ONE && opnd1 == MINUS_ONE) ? S_OVERFLOW : S_CALC;
        end else begin
          next_mag_b = abs16(opnd2);
          next_rem   = dmag[30:15];
          next_dq    = dmag[14:0];
          next_neg   = acc_q[15] ^ opnd2[15];
          next_state = (abs16(opnd2) <= dmag[30:15]) ? S_OVERFLOW : S_CALC;
        end
      end
      // [RULE_05] Shift-add multiply
      S_CALC: begin
        next_cnt = cnt + 5'h01;
        if (!op_div) begin
          if (mag_b[cnt[3:0]])
            next_prod = prod + (31'(mag_a) << cnt);
          if (cnt == MUL_LAST_STEP) begin
            next_state = S_WRITE;
          end
        end else begin
          // [RULE_06] Restoring divide
          if (trial >= {1'b0, mag_b}) begin
            next_rem = 16'(trial - {1'b0, mag_b});
            next_dq  = {dq[13:0], 1'b1};
          end else begin
            next_rem = trial[15:0];
            next_dq  = {dq[13:0], 1'b0};
          end
          if (cnt == DIV_LAST_STEP) begin
            next_state = S_FINISH;
          end
        end
        // [RULE_02] Product halves out
        if (!op_div && cnt == MUL_LAST_STEP) begin
          next_mem_wdata = {1'b0, 15'(next_prod_signed(next_prod, neg))};
          next_acc_out   = 16'(next_prod_signed(next_prod, neg) >> FRAC_WIDTH);
        end
        // [RULE_04] Quotient to accumulator
        if (op_div && cnt == DIV_LAST_STEP) begin
          next_acc_out = neg ? 16'(-{1'b0, next_dq}) : {1'b0, next_dq};
        end
      end
      // [RULE_02] Low product write
      S_WRITE: begin
        if (mem_ack)
          next_state = S_FINISH;
      end
      S_FINISH:   next_state = S_IDLE;
      S_OVERFLOW: next_state = S_IDLE;
      default:    next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state     <= S_IDLE;
      op_div    <= 1'b0;
      acc_q     <= '0;
      pa        <= '0;
      pb        <= '0;
      opnd1     <= '0;
      opnd2     <= '0;
      mag_a     <= '0;
      mag_b     <= '0;
      prod      <= '0;
      rem       <= '0;
      dq        <= '0;
      cnt       <= '0;
      neg       <= 1'b0;
      acc_out   <= '0;
      mem_wdata <= '0;
    end else begin
      state     <= next_state;
      op_div    <= next_op_div;
      acc_q     <= next_acc_q;
      pa        <= next_pa;
      pb        <= next_pb;
      opnd1     <= next_opnd1;
      opnd2     <= next_opnd2;
      mag_a     <= next_mag_a;
      mag_b     <= next_mag_b;
      prod      <= next_prod;
      rem       <= next_rem;
      dq        <= next_dq;
      cnt       <= next_cnt;
      neg       <= next_neg;
      acc_out   <= next_acc_out;
      mem_wdata <= next_mem_wdata;
    end
  end

  // [RULE_07] Hold processor while active
  assign suspend      = (state != S_IDLE) && (state != S_WAIT_END);
  assign busy         = (state != S_IDLE);
  assign mem_req      = (state == S_FETCH1) || (state == S_FETCH2) || (state == S_WRITE);
  assign mem_we       = (state == S_WRITE);
  assign mem_addr     = (state == S_FETCH1) ? pa : pb;
  // [RULE_09] Release after write-back
  assign acc_load     = (state == S_FINISH);
  // [RULE_08] Overflow indicator pulse
  assign overflow_set = (state == S_OVERFLOW);

  // Assertion helpers: elapsed suspended cycles and reference results
  logic [9:0]         elapsed;
  logic signed [31:0] ref_prod;
  logic signed [30:0] ref_quot;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn)
      elapsed <= '0;
    else if (!suspend)
      elapsed <= '0;
    else if (elapsed != 10'h3ff)
      elapsed <= elapsed + 10'h001;
  end
  assign ref_prod = $signed(acc_q) * $signed(opnd1);
  assign ref_quot = $signed({acc_q, opnd1[14:0]}) / $signed({{15{opnd2[15]}}, opnd2});

  sequence s_write_done;
    (state == S_WRITE) && mem_ack;
  endsequence
  sequence s_release;
    acc_load ##1 !suspend;
  endsequence

  a_suspend_boundary: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_07]
    $rose(suspend) |-> $past(instr_end)) else $error("suspend rose without instruction end");
  a_mem_suspended: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_07]
    mem_req |-> suspend) else $error("memory access while processor running");
  a_mul_fetch: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_01]
    (state == S_FETCH1) |-> (mem_addr == pa && !mem_we)) else $error("bad first operand fetch");
  a_div_divisor: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_03]
    (state == S_FETCH2) |-> (mem_addr == pb && op_div && !mem_we)) else $error("bad divisor fetch");
  a_low_write: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_02]
    mem_we |-> (!op_div && mem_addr == pb && mem_wdata == {1'b0, ref_prod[14:0]}))
    else $error("bad low product write");
  a_mul_high: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_02]
    (acc_load && !op_div) |-> acc_out == ref_prod[30:15]) else $error("bad high product");
  a_div_quot: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_04]
    (acc_load && op_div) |-> acc_out == ref_quot[15:0]) else $error("bad quotient");
  a_ovf_untouched: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_08]
    overflow_set |-> !acc_load && !mem_we && $past(state) == S_SETUP ##1 !suspend)
    else $error("overflow changed operands");
  a_mul_time: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_05]
    (acc_load && !op_div) |-> elapsed < 10'(MUL_CYCLES)) else $error("multiply too slow");
  a_div_time: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_06]
    (acc_load && op_div) |-> elapsed < 10'(DIV_CYCLES)) else $error("divide too slow");
  a_release_order: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE_09]
    s_write_done |=> s_release) else $error("released before write-back");

endmodule

`default_nettype wire

// >>> host_memory_model.sv
`timescale 1ns/1ps
`default_nettype none

module host_memory_model (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic [3:0]  latency,
  input  wire logic        suspend,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [15:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  output logic      [15:0] mem_rdata,
  output logic             mem_ack,
  output logic             instr_end
);
  logic [15:0] mem [0:255];
  logic [3:0]  wait_cnt;
  logic [1:0]  step;

  assign instr_end = (step == 2'h3) && !suspend;

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wait_cnt  <= 4'h0;
      step      <= 2'h0;
      mem_ack   <= 1'b0;
      mem_rdata <= 16'hffff;
    end else begin
      step      <= step + 2'h1;
      mem_ack   <= 1'b0;
      // Idle data bus keeps changing
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
        wait_cnt <= wait_cnt + 4'h1;
        if (wait_cnt == latency) begin
          wait_cnt  <= 4'h0;
          mem_ack   <= 1'b1;
          mem_rdata <= mem[mem_addr[7:0]];
        end
      end
      if (mem_req && mem_ack && mem_we) begin
        mem[mem_addr[7:0]] <= mem_wdata;
      end
    end
  end
endmodule

`default_nettype wire

// >>> hw_multiply_divide_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none

module hw_multiply_divide_unit_tb;
  import muldiv_pkg::*;
  logic        sys_clk = 0, resetn = 0, op_start = 0, op_divide = 0;
  logic [15:0] acc_in = 0, ptr_a = 0, ptr_b = 0, mem_addr, mem_wdata, mem_rdata, acc_out;
  logic        instr_end, suspend, busy, mem_req, mem_we, mem_ack, acc_load, overflow_set;
  logic [3:0]  latency = 0;
  int          failures = 0, checks_done = 0, cycles = 0;

  always #12.5 sys_clk = ~sys_clk;

  hw_multiply_divide_unit hw_multiply_divide_unit_inst (.sys_clk, .resetn, .op_start,
    .op_divide, .acc_in, .ptr_a, .ptr_b, .instr_end, .suspend, .busy, .mem_req, .mem_we,
    .mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .acc_load, .acc_out, .overflow_set);

  host_memory_model host_memory_model_inst (.sys_clk, .resetn, .latency, .suspend,
    .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .instr_end);

  task automatic check(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic run_op(input logic dv, input logic [15:0] a, pa, pb, wa, wb,
                        input logic [3:0] lat, input logic ovf, input logic [15:0] ea, eb);
    int   n;
    logic done, s_ovf, s_load, l_sus, l_end;
    logic [15:0] prev;
    n = 0;
    done = 0;
    s_ovf = 0;
    s_load = 0;
    l_sus = 0;
    l_end = 0;
    prev = acc_out;
    host_memory_model_inst.mem[pa[7:0]] = wa;
    host_memory_model_inst.mem[pb[7:0]] = wb;
    latency = lat;
    op_divide = dv;
    acc_in = a;
    ptr_a = pa;
    ptr_b = pb;
    op_start = 1;
    @(posedge sys_clk);
    #1 op_start = 0;
    l_end = instr_end;
    check("busy", busy, 1);
    while (!done && n < 1000) begin
      @(posedge sys_clk);
      #1;
      if (suspend && !l_sus) check("end before hold", l_end, 1);
      l_sus = suspend;
      l_end = instr_end;
      if (suspend) n++;
      s_ovf = s_ovf | overflow_set;
      s_load = s_load | acc_load;
      done = acc_load | overflow_set;
    end
    check("overflow", s_ovf, ovf);
    check("acc load", s_load, !ovf);
    if (!ovf) check("acc result", acc_out, ea);
    if (ovf) check("acc kept", acc_out, prev);
    check("word a", host_memory_model_inst.mem[pa[7:0]], wa);
    check("word b", host_memory_model_inst.mem[pb[7:0]], eb);
    check("time", n <= (dv ? DIV_CYCLES : MUL_CYCLES), 1);
    @(posedge sys_clk);
    #1;
    check("busy idle", busy, 0);
    check("suspend idle", suspend, 0);
  endtask

  task automatic test_multiply(input logic [15:0] a, b, input logic [3:0] lat);
    logic signed [31:0] p;
    p = $signed(a) * $signed(b);
    run_op(0, a, 16'h0010, 16'h0011, b, 16'h5a5a, lat, 0, p[30:15], {1'b0, p[14:0]});
    $display("test multiply done");
  endtask

  task automatic test_divide(input logic [15:0] hi, lo, d, input logic [3:0] lat);
    logic signed [30:0] q;
    q = $signed({hi, lo[14:0]}) / $signed({{15{d[15]}}, d});
    run_op(1, hi, 16'h0020, 16'h0021, lo, d, lat, 0, q[15:0], d);
    $display("test divide done");
  endtask

  task automatic test_overflow();
    run_op(0, 16'h8000, 16'h0030, 16'h0031, 16'h8000, 16'h1111, 4'h1, 1, 16'h0, 16'h1111);
    run_op(1, 16'h0003, 16'h0032, 16'h0033, 16'h0004, 16'h0000, 4'h2, 1, 16'h0, 16'h0000);
    $display("test overflow done");
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      final_report();
    end
  end

  initial begin
    repeat (5) @(posedge sys_clk);
    #1 resetn = 1;
    test_multiply(16'h1234, 16'h0101, 4'h0);
    test_multiply(16'hfff0, 16'h0300, 4'h3);
    test_divide(16'h0001, 16'h2345, 16'h0100, 4'h1);
    test_divide(16'hffff, 16'h0010, 16'h0007, 4'h4);
    test_overflow();
    final_report();
  end
endmodule

`default_nettype wire
